// ### pkg/dfpf_pkg.sv
/*
  Shared constants and carrier types of the direction-finding test packet
  framer: field patterns, field layouts, timing counts and config structs.
  Assumes a 10 MHz system clock and the uncoded 1 and 2 Msym/s rates.
*/
`default_nettype none
package dfpf_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SYM1_NS = 1000;
  localparam int SYM2_NS = 500;
  localparam int US_NS = 1000;
  localparam int SYM1_CYC = SYM1_NS / CLK_PERIOD_NS;
  localparam int SYM2_CYC = SYM2_NS / CLK_PERIOD_NS;
  localparam int US_CYC = US_NS / CLK_PERIOD_NS;
  localparam logic [3:0] SYM1_LAST = 4'(SYM1_CYC - 1);
  localparam logic [3:0] SYM2_LAST = 4'(SYM2_CYC - 1);
  localparam logic [3:0] SYM1_MID = 4'(SYM1_CYC / 2);
  localparam logic [3:0] SYM2_MID = 4'(SYM2_CYC / 2);
  localparam logic [3:0] US_LAST = 4'(US_CYC - 1);

  // ----------------------------------------------------------------------
  // Fixed fields, held least significant bit first on the air
  // ----------------------------------------------------------------------
  localparam logic [15:0] PREAMBLE = 16'h5555;
  localparam logic [4:0] PRE1_LAST = 5'h07;
  localparam logic [4:0] PRE2_LAST = 5'h0F;
  localparam logic [31:0] SYNC_WORD = 32'h71764129;
  localparam logic [4:0] WORD_LAST = 5'h1F;
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [4:0] CRC_LAST = 5'h17;

  // ----------------------------------------------------------------------
  // Payload types and patterns
  // ----------------------------------------------------------------------
  localparam logic [3:0] PT_PRBS9 = 4'h0;
  localparam logic [3:0] PT_NIBBLE = 4'h1;
  localparam logic [3:0] PT_ALT = 4'h2;
  localparam logic [7:0] BYTE_NIBBLE = 8'h0F;
  localparam logic [7:0] BYTE_ALT = 8'h55;
  localparam logic [8:0] PRBS_SEED = 9'h1FF;
  localparam logic [23:0] CRC_POLY = 24'h00065B;
  localparam logic [23:0] CRC_INIT = 24'h555555;

  // ----------------------------------------------------------------------
  // Header and extension-info layout
  // ----------------------------------------------------------------------
  localparam int HDR_CP_BIT = 5;
  localparam int INFO_RFU_BIT = 5;
  localparam int INFO_TYPE_LSB = 6;
  localparam logic [4:0] CTE_TIME_MIN = 5'h02;
  localparam logic [4:0] CTE_TIME_MAX = 5'h14;
  localparam int CTE_UNIT_US = 8;
  localparam logic [1:0] CTE_AOA = 2'h0;
  localparam logic [1:0] CTE_AOD1 = 2'h1;
  localparam logic [1:0] CTE_AOD2 = 2'h2;
  localparam logic [1:0] CTE_RSVD = 2'h3;
  localparam logic [7:0] GUARD_US = 8'h04;
  localparam logic [7:0] SLOT_START_US = 8'h0C;

  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 32;

  typedef struct packed {
    logic phy_2m;
    logic [3:0] ptype;
    logic [7:0] length;
    logic info_present;
    logic [4:0] cte_time;
    logic [1:0] cte_type;
  } dfpf_cfg_type;

  typedef struct packed {
    logic [3:0] pat_len;
    logic [15:0][1:0] pattern;
  } dfpf_ant_type;

  typedef enum logic [3:0] {
    PH_IDLE, PH_PRE, PH_SYNC, PH_HDR, PH_LEN, PH_INFO, PH_PAY, PH_CRC,
    PH_CTE
  } dfpf_phase_type;

endpackage
`default_nettype wire

// ### core/dfpf_top.sv
/*
  Test packet framer with tone extension: pattern FIFO, transmit
  serializer, receive parser and the shared extension slot sequencer.
  Assumes one 10 MHz clock; rx_pin comes from the demodulator's domain.
*/
`timescale 1ns/1ps
`default_nettype none

module dfpf_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // Clock and freeze
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [AW:0] count;
  logic push, pop;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// Operation
// RULE_01: 1M preamble is eight alternating bits
// RULE_02: 2M preamble is sixteen alternating bits
// RULE_03: Fixed sync word sent and correlated
// RULE_04: Type 0000 gives PRBS9 payload
// RULE_05: Type 0001 gives repeated 11110000
// RULE_06: Type 0010 gives repeated 10101010
// RULE_07: Length field sets exact payload byte count
// RULE_08: Payload holds only the selected pattern
// RULE_09: CRC-24 over PDU, extension excluded
// RULE_10: Extension only on uncoded rates, no CRC
// RULE_11: Info flag marks info byte and extension
// RULE_12: Set flag carries time, type, extension
// RULE_13: Info byte is time, reserved, type
// RULE_14: Time in 8 us units, 2..20 valid
// RULE_15: Type 0 AoA, 1/2 AoD slots, 3 reserved
// RULE_16: Extension is unwhitened ones for its time
// RULE_17: Guard 4 us, reference 8 us, slots
// RULE_18: Both 2 us and 1 us slots supported
// RULE_19: AoA transmit keeps one antenna
// RULE_20: AoA receive switches per host pattern
// RULE_21: Up to 74 or 37 slot pairs
// RULE_22: AoD transmit switches, AoD receive samples
// RULE_23: Reference antenna first, pattern then cycles
// RULE_24: Sample each reference us, each sample slot
// RULE_25: Info bits: time 4:0, zero 5, type 7:6
// RULE_26: Fields LSB first, reserved info flagged
module dfpf_top (
  // Clock, reset and freeze
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Transmit request and configuration
  input wire dfpf_pkg::dfpf_cfg_type tx_cfg,
  input wire logic tx_start,
  output logic tx_busy,
  // Transmit symbol stream
  output logic tx_bit,
  output logic tx_en,
  // Receive control and symbol stream
  input wire logic rx_en,
  input wire logic rx_phy_2m,
  input wire logic rx_slot_2us,
  input wire logic rx_pin,
  // Received fields and status
  output logic [7:0] rx_data,
  output logic rx_valid,
  output dfpf_pkg::dfpf_cfg_type rx_hdr,
  output logic rx_done,
  output logic rx_crc_ok,
  output logic rx_info_bad,
  // Antenna array and IQ capture
  input wire dfpf_pkg::dfpf_ant_type ant_cfg,
  output logic [1:0] ant_sel,
  output logic iq_sample
);
  import dfpf_pkg::*;

  function automatic logic [23:0] crc_step(input logic [23:0] c,
                                           input logic b);
    return {c[22:0], 1'b0} ^ ((c[23] ^ b) ? CRC_POLY : 24'h000000);
  endfunction

  function automatic logic [16:0] prbs_byte(input logic [8:0] s);
    logic [8:0] st;
    logic [7:0] b;
    st = s;
    b = '0;
    for (int i = 0; i < 8; i++) begin
      b[i] = st[0];
      st = {st[0] ^ st[4], st[8:1]};
    end
    return {st, b};
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  dfpf_cfg_type tx_q;
  dfpf_phase_type tx_ph, next_ph, rx_ph;
  logic [3:0] tx_cyc, rx_cyc, us_cyc, pat_idx;
  logic [31:0] tx_sr, next_sr, rx_sh, sh_n;
  logic [4:0] tx_left, next_left, rx_cnt;
  logic [23:0] tx_crc, rx_crc;
  logic [7:0] pay_left, gen_left, rx_left, hdr_byte, info_byte;
  logic [8:0] prbs;
  logic [16:0] prbs_n;
  logic [7:0] gen_byte, fifo_data, cte_t, cte_end, cte_t_n;
  logic tx_ok, tx_tick, field_end, tx_pop, fifo_valid;
  logic gen_ready, gen_valid, pdu;
  logic rx_m, rx_s, rx_d, rx_smp, rx_end, rx_cte_go, tx_cte_go;
  logic cte_run, cte_done, cte_sw, cte_smp, cte_s2, us_tick;
  logic [1:0] slot_pos;
  logic [4:0] go_time;

  // ----------------------------------------------------------------------
  // Payload pattern source and FIFO
  // ----------------------------------------------------------------------
  assign prbs_n = prbs_byte(prbs);
  // RULE_04: PRBS9 payload
  // RULE_05: Nibble pattern
  // RULE_06: Alternating pattern
  assign gen_byte = (tx_q.ptype == PT_NIBBLE) ? BYTE_NIBBLE :
                    (tx_q.ptype == PT_ALT) ? BYTE_ALT : prbs_n[7:0];
  assign gen_valid = gen_left != 8'h00;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gen_left <= 8'h00;
      prbs <= PRBS_SEED;
    end else if (ce) begin
      if (tx_ph == PH_IDLE && tx_start && tx_ok) begin
        // RULE_07: Exact byte count
        gen_left <= tx_cfg.length;
        prbs <= PRBS_SEED;
      end else if (gen_valid && gen_ready) begin
        gen_left <= gen_left - 8'h01;
        prbs <= prbs_n[16:8];
      end
    end
  end

  // The source runs far ahead of the line rate; a full FIFO stalls it.
  dfpf_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(mclk),
    .resetn(resetn),
    .ce(ce),
    .in_valid(gen_valid),
    .in_ready(gen_ready),
    .in_data(gen_byte),
    .out_valid(fifo_valid),
    .out_ready(tx_pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------------
  // Transmit serializer
  // ----------------------------------------------------------------------
  // RULE_14: Reserved values refused
  // RULE_15: Reserved type refused
  assign tx_ok = (tx_cfg.ptype <= PT_ALT) && (!tx_cfg.info_present ||
                 (tx_cfg.cte_time >= CTE_TIME_MIN &&
                  tx_cfg.cte_time <= CTE_TIME_MAX &&
                  tx_cfg.cte_type != CTE_RSVD));
  assign tx_tick = (tx_ph != PH_IDLE) &&
                   (tx_cyc == (tx_q.phy_2m ? SYM2_LAST : SYM1_LAST));
  assign field_end = tx_tick && tx_left == 5'h00 && tx_ph != PH_CTE;
  assign tx_pop = field_end && next_ph == PH_PAY;
  assign tx_cte_go = field_end && next_ph == PH_CTE;
  // RULE_10: Extension outside CRC
  assign pdu = tx_ph inside {PH_HDR, PH_LEN, PH_INFO, PH_PAY};
  assign tx_bit = tx_sr[0];
  assign tx_busy = tx_ph != PH_IDLE;
  assign tx_en = tx_busy;

  always_comb begin
    hdr_byte = 8'h00;
    hdr_byte[3:0] = tx_q.ptype;
    // RULE_11: Info-present flag
    hdr_byte[HDR_CP_BIT] = tx_q.info_present;
    // RULE_13: Info byte fields
    // RULE_25: Reserved bit zero
    info_byte = 8'h00;
    info_byte[4:0] = tx_q.cte_time;
    info_byte[INFO_RFU_BIT] = 1'b0;
    info_byte[INFO_TYPE_LSB +: 2] = tx_q.cte_type;
  end

  always_comb begin
    next_ph = PH_IDLE;
    next_sr = 32'h00000000;
    next_left = BYTE_LAST;
    case (tx_ph)
      PH_PRE: next_ph = PH_SYNC;
      PH_SYNC: next_ph = PH_HDR;
      PH_HDR: next_ph = PH_LEN;
      // RULE_12: Info byte when flagged
      PH_LEN: next_ph = tx_q.info_present ? PH_INFO : PH_PAY;
      PH_INFO: next_ph = PH_PAY;
      PH_PAY: next_ph = PH_PAY;
      PH_CRC: next_ph = tx_q.info_present ? PH_CTE : PH_IDLE;
      default: next_ph = PH_IDLE;
    endcase
    if (next_ph == PH_PAY && pay_left == 8'h00) begin
      next_ph = PH_CRC;
    end
    case (next_ph)
      // RULE_03: Sync word
      PH_SYNC: begin
        next_sr = SYNC_WORD;
        next_left = WORD_LAST;
      end
      // RULE_26: LSB first fields
      PH_HDR: next_sr = {24'h000000, hdr_byte};
      PH_LEN: next_sr = {24'h000000, tx_q.length};
      PH_INFO: next_sr = {24'h000000, info_byte};
      PH_PAY: next_sr = {24'h000000, fifo_data};
      // RULE_09: Append CRC
      PH_CRC: begin
        next_sr = {8'h00, crc_step(tx_crc, tx_sr[0])};
        next_left = CRC_LAST;
      end
      // RULE_16: Unwhitened ones
      PH_CTE: next_sr = 32'hFFFFFFFF;
      default: next_sr = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_cyc <= 4'h0;
    end else if (ce) begin
      tx_cyc <= (tx_ph == PH_IDLE || tx_tick) ? 4'h0 : tx_cyc + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_ph <= PH_IDLE;
      tx_q <= '0;
      tx_sr <= 32'h00000000;
      tx_left <= 5'h00;
      tx_crc <= CRC_INIT;
      pay_left <= 8'h00;
    end else if (ce) begin
      if (tx_ph == PH_IDLE) begin
        if (tx_start && tx_ok) begin
          tx_q <= tx_cfg;
          tx_ph <= PH_PRE;
          // RULE_01: Eight-bit preamble
          // RULE_02: Sixteen-bit preamble
          tx_sr <= {16'h0000, PREAMBLE};
          tx_left <= tx_cfg.phy_2m ? PRE2_LAST : PRE1_LAST;
          tx_crc <= CRC_INIT;
          pay_left <= tx_cfg.length;
        end
      end else if (tx_ph == PH_CTE) begin
        if (cte_done) begin
          tx_ph <= PH_IDLE;
          tx_sr <= 32'h00000000;
        end
      end else if (tx_tick) begin
        if (pdu) begin
          // RULE_09: PDU only
          tx_crc <= crc_step(tx_crc, tx_sr[0]);
        end
        if (field_end) begin
          tx_ph <= next_ph;
          tx_sr <= next_sr;
          tx_left <= next_left;
          if (tx_pop) begin
            // RULE_08: Pattern bytes only
            pay_left <= pay_left - 8'h01;
          end
        end else begin
          tx_sr <= {1'b1, tx_sr[31:1]};
          tx_left <= tx_left - 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive parser
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_m <= 1'b0;
      rx_s <= 1'b0;
      rx_d <= 1'b0;
      rx_cyc <= 4'h0;
    end else if (ce) begin
      rx_m <= rx_pin;
      rx_s <= rx_m;
      rx_d <= rx_s;
      if (rx_s != rx_d ||
          rx_cyc == (rx_phy_2m ? SYM2_LAST : SYM1_LAST)) begin
        rx_cyc <= 4'h0;
      end else begin
        rx_cyc <= rx_cyc + 4'h1;
      end
    end
  end

  assign rx_smp = ce && rx_cyc == (rx_phy_2m ? SYM2_MID : SYM1_MID);
  assign sh_n = {rx_s, rx_sh[31:1]};
  assign rx_end = rx_smp && rx_cnt == 5'h00;
  assign rx_cte_go = rx_end && rx_ph == PH_CRC && rx_hdr.info_present &&
                     !rx_info_bad;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_ph <= PH_IDLE;
      rx_sh <= 32'h00000000;
      rx_cnt <= 5'h00;
      rx_crc <= CRC_INIT;
      rx_left <= 8'h00;
      rx_hdr <= '0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_done <= 1'b0;
      rx_crc_ok <= 1'b0;
      rx_info_bad <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      rx_done <= 1'b0;
      if (rx_ph == PH_CTE) begin
        if (cte_done) begin
          rx_ph <= PH_IDLE;
        end
      end else if (rx_smp) begin
        rx_sh <= sh_n;
        rx_cnt <= rx_cnt - 5'h01;
        if (rx_ph inside {PH_HDR, PH_LEN, PH_INFO, PH_PAY}) begin
          rx_crc <= crc_step(rx_crc, rx_s);
        end
        case (rx_ph)
          PH_IDLE: begin
            // RULE_03: Correlate sync word
            if (rx_en && sh_n == SYNC_WORD) begin
              rx_ph <= PH_HDR;
              rx_cnt <= BYTE_LAST;
              rx_crc <= CRC_INIT;
              rx_info_bad <= 1'b0;
              rx_hdr <= '0;
              rx_hdr.phy_2m <= rx_phy_2m;
            end
          end
          PH_HDR: begin
            if (rx_cnt == 5'h00) begin
              rx_hdr.ptype <= sh_n[27:24];
              rx_hdr.info_present <= sh_n[24 + HDR_CP_BIT];
              rx_ph <= PH_LEN;
              rx_cnt <= BYTE_LAST;
            end
          end
          PH_LEN: begin
            if (rx_cnt == 5'h00) begin
              // RULE_07: Received byte count
              rx_hdr.length <= sh_n[31:24];
              rx_left <= sh_n[31:24];
              rx_cnt <= BYTE_LAST;
              if (rx_hdr.info_present) begin
                rx_ph <= PH_INFO;
              end else if (sh_n[31:24] == 8'h00) begin
                rx_ph <= PH_CRC;
                rx_cnt <= CRC_LAST;
              end else begin
                rx_ph <= PH_PAY;
              end
            end
          end
          PH_INFO: begin
            if (rx_cnt == 5'h00) begin
              // RULE_25: Reserved bit ignored
              rx_hdr.cte_time <= sh_n[28:24];
              rx_hdr.cte_type <= sh_n[24 + INFO_TYPE_LSB +: 2];
              // RULE_26: Flag reserved values
              rx_info_bad <= sh_n[28:24] < CTE_TIME_MIN ||
                             sh_n[28:24] > CTE_TIME_MAX ||
                             sh_n[24 + INFO_TYPE_LSB +: 2] == CTE_RSVD;
              rx_cnt <= BYTE_LAST;
              if (rx_left == 8'h00) begin
                rx_ph <= PH_CRC;
                rx_cnt <= CRC_LAST;
              end else begin
                rx_ph <= PH_PAY;
              end
            end
          end
          PH_PAY: begin
            if (rx_cnt == 5'h00) begin
              rx_data <= sh_n[31:24];
              rx_valid <= 1'b1;
              rx_left <= rx_left - 8'h01;
              rx_cnt <= BYTE_LAST;
              if (rx_left == 8'h01) begin
                rx_ph <= PH_CRC;
                rx_cnt <= CRC_LAST;
              end
            end
          end
          PH_CRC: begin
            if (rx_cnt == 5'h00) begin
              // RULE_09: Check received CRC
              rx_crc_ok <= sh_n[31:8] == rx_crc;
              rx_done <= 1'b1;
              rx_ph <= rx_cte_go ? PH_CTE : PH_IDLE;
            end
          end
          default: rx_ph <= PH_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Extension slot sequencer, shared since the radio is half duplex
  // ----------------------------------------------------------------------
  assign us_tick = cte_run && us_cyc == US_LAST;
  assign cte_t_n = cte_t + 8'h01;
  assign go_time = tx_cte_go ? tx_q.cte_time : rx_hdr.cte_time;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cte_run <= 1'b0;
      cte_done <= 1'b0;
      cte_sw <= 1'b0;
      cte_smp <= 1'b0;
      cte_s2 <= 1'b0;
      cte_t <= 8'h00;
      cte_end <= 8'h00;
      us_cyc <= 4'h0;
      slot_pos <= 2'h0;
      pat_idx <= 4'h0;
      ant_sel <= 2'h0;
      iq_sample <= 1'b0;
    end else if (ce) begin
      cte_done <= 1'b0;
      iq_sample <= 1'b0;
      if (tx_cte_go || rx_cte_go) begin
        cte_run <= 1'b1;
        cte_t <= 8'h00;
        us_cyc <= 4'h0;
        // RULE_14: Units of 8 us
        cte_end <= 8'({3'h0, go_time} * CTE_UNIT_US - 1);
        if (tx_cte_go) begin
          // RULE_19: AoA transmit fixed
          // RULE_22: AoD transmit switches
          cte_sw <= tx_q.cte_type != CTE_AOA;
          cte_smp <= 1'b0;
          cte_s2 <= tx_q.cte_type == CTE_AOD2;
        end else begin
          // RULE_20: AoA receive switches
          // RULE_18: Both slot lengths
          cte_sw <= rx_hdr.cte_type == CTE_AOA;
          cte_smp <= 1'b1;
          cte_s2 <= (rx_hdr.cte_type == CTE_AOA) ? rx_slot_2us :
                    rx_hdr.cte_type == CTE_AOD2;
        end
        // RULE_23: Reference antenna first
        pat_idx <= 4'h0;
        ant_sel <= ant_cfg.pattern[0];
      end else if (cte_run) begin
        us_cyc <= us_tick ? 4'h0 : us_cyc + 4'h1;
        if (us_tick) begin
          cte_t <= cte_t_n;
          if (cte_t == cte_end) begin
            cte_run <= 1'b0;
            cte_done <= 1'b1;
          // RULE_17: Guard then reference
          // RULE_24: Reference samples
          end else if (cte_t_n < SLOT_START_US) begin
            iq_sample <= cte_smp && cte_t_n >= GUARD_US;
          end else begin
            // RULE_21: Slot pairs to the end
            if (cte_t_n == SLOT_START_US ||
                slot_pos == (cte_s2 ? 2'h3 : 2'h1)) begin
              slot_pos <= 2'h0;
              if (cte_sw) begin
                // RULE_23: Pattern cycles
                pat_idx <= (pat_idx >= ant_cfg.pat_len - 4'h1) ? 4'h0 :
                           pat_idx + 4'h1;
                ant_sel <= (pat_idx >= ant_cfg.pat_len - 4'h1) ?
                           ant_cfg.pattern[0] :
                           ant_cfg.pattern[pat_idx + 4'h1];
              end
            end else begin
              slot_pos <= slot_pos + 2'h1;
              // RULE_24: One sample per slot
              iq_sample <= cte_smp &&
                           slot_pos == (cte_s2 ? 2'h1 : 2'h0);
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/dfpf_sva.sv
/* Port checker of the framer, bound into its top module.
   Assumes tx_cfg is held steady while tx_busy is high. */
`timescale 1ns/1ps
`default_nettype none
module dfpf_chk (
  // Watched ports
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire dfpf_pkg::dfpf_cfg_type tx_cfg,
  input wire logic tx_start,
  input wire logic tx_busy,
  input wire logic tx_bit,
  input wire logic rx_valid,
  input wire logic rx_done,
  input wire logic rx_crc_ok,
  input wire dfpf_pkg::dfpf_ant_type ant_cfg,
  input wire logic [1:0] ant_sel,
  input wire logic iq_sample
);
  import dfpf_pkg::*;
  logic ok;
  logic aoa;
  assign ok = tx_cfg.ptype <= PT_ALT && (!tx_cfg.info_present
    || (tx_cfg.cte_time inside {[CTE_TIME_MIN:CTE_TIME_MAX]}
    && tx_cfg.cte_type != CTE_RSVD));
  assign aoa = tx_cfg.info_present && tx_cfg.cte_type == CTE_AOA;
  // A low ce stretches every count, so checks pause meanwhile.
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn || !ce);
  a_start_taken: assert property (
    !tx_busy && tx_start && ok |=> tx_busy && tx_bit) else $error("no start");
  a_bad_refused: assert property (
    !tx_busy && tx_start && !ok |=> !tx_busy) else $error("bad cfg taken");
  a_pre_slow: assert property (
    $rose(tx_busy) && !tx_cfg.phy_2m |-> tx_bit[*8] ##1 tx_bit[*2]
    ##1 !tx_bit[*8] ##1 !tx_bit[*2] ##1 tx_bit) else $error("1M preamble");
  a_pre_fast: assert property (
    $rose(tx_busy) && tx_cfg.phy_2m |-> tx_bit[*5] ##1 !tx_bit[*5]
    ##1 tx_bit) else $error("2M preamble");
  a_aoa_one_ant: assert property (
    tx_busy && $past(tx_busy) && aoa |-> $stable(ant_sel)
    || ant_sel == ant_cfg.pattern[0]) else $error("AoA tx switched");
  a_iq_gap: assert property (
    iq_sample |=> !iq_sample[*8]) else $error("samples too close");
  a_byte_pulse: assert property (
    rx_valid |=> !rx_valid[*8]) else $error("byte pulse");
  a_done_pulse: assert property (
    rx_done |=> !rx_done[*8]) else $error("done pulse");
  c_crc_good: cover property (rx_done && rx_crc_ok);
  c_iq_taken: cover property (iq_sample);
  c_aoa_sent: cover property (tx_busy && aoa);
endmodule
bind dfpf_top dfpf_chk i_chk (.*);
`default_nettype wire

// ### sim/dfpf_peer.sv
/* Far-side peer: echoes the framer's own air stream after a delay.
   Assumes one shared clock; it needs no reset. */
`timescale 1ns/1ps
`default_nettype none
module dfpf_peer #(
  parameter int DELAY = 2000
) (
  // Air side
  input wire logic mclk,
  input wire logic tx_bit,
  input wire logic tx_en,
  output logic rx_pin
);
  logic [DELAY-1:0] bits = '0;
  logic [DELAY-1:0] keys = '0;
  logic idle = 1'b0;
  // The delay keeps the echoed extension clear of the sender's own one.
  // Echo whole frames.
  always @(posedge mclk) begin
    bits <= {bits[DELAY-2:0], tx_bit};
    keys <= {keys[DELAY-2:0], tx_en};
    idle <= ~idle;
  end
  // Off the air the line flips each cycle instead of holding a level.
  assign rx_pin = keys[DELAY-1] ? bits[DELAY-1] : idle;
endmodule
`default_nettype wire

// ### sim/dfpf_top_bench.sv
/* Bench of the framer, looped back through the peer model.
   Assumes ce stays high and one 10 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module dfpf_top_bench;
  import dfpf_pkg::*;
  logic mclk, resetn, ce, tx_start, tx_busy, tx_bit, tx_en, rx_en, rx_pin;
  logic rx_phy_2m, rx_slot_2us, rx_valid, rx_done, rx_crc_ok, rx_info_bad;
  logic iq_sample;
  logic [1:0] ant_sel;
  logic [7:0] rx_data;
  logic [8:0] ps;
  logic [31:0] seed = 32'h0000004A;
  logic [7:0] q[$];
  dfpf_cfg_type tx_cfg, rx_hdr, c;
  dfpf_ant_type ant_cfg;
  int bad_count = 0, n_compared = 0, n_done = 0, w;
  dfpf_top i_dfpf_top (.*);
  dfpf_peer i_dfpf_peer (.mclk, .tx_bit, .tx_en, .rx_pin);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_byte(input logic [3:0] pt);
    logic [7:0] b;
    for (int i = 0; i < 8; i++) begin
      b[i] = ps[0];
      ps = {ps[0] ^ ps[4], ps[8:1]};
    end
    return pt == 4'h1 ? 8'h0F : pt == 4'h2 ? 8'h55 : b;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic send(input dfpf_cfg_type cf, input logic on);
    int sym;
    int np;
    sym = cf.phy_2m ? 5 : 10;
    np = cf.phy_2m ? 16 : 8;
    {rx_en, rx_phy_2m} = {on, cf.phy_2m};
    ant_cfg = 36'({rnd(), rnd()});
    rx_slot_2us = seed[3];
    q.delete();
    {n_done, ps, tx_cfg, tx_start} = {32'h0, 9'h1FF, cf, 1'b1};
    @(posedge mclk);
    #1 tx_start = 1'b0;
    repeat (sym / 2 + 1) @(posedge mclk);
    for (int i = 0; i < np + 32; i++) begin
      #1;
      if (i == 0) chk(8'(tx_en), 8'h01);
      if (i < np) chk(8'(tx_bit), 8'(!i[0]));
      else chk(8'(tx_bit), 8'(SYNC_WORD[i - np]));
      repeat (sym) @(posedge mclk);
    end
    for (w = 0; n_done == 0 && w < 8000; w++) @(posedge mclk);
    #1 chk(8'(n_done), 8'(on));
    if (on) begin
      chk(8'(rx_crc_ok), 8'h01);
      chk(8'(q.size()), cf.length);
      foreach (q[j]) chk(q[j], exp_byte(cf.ptype));
      if (cf.ptype == PT_PRBS9) chk(q[0], 8'hFF);
      if (cf.ptype == PT_PRBS9 && cf.length > 1) chk(q[1], 8'hC1);
      chk(rx_hdr.length, cf.length);
      chk({rx_hdr.cte_type, rx_hdr.info_present, rx_hdr.cte_time},
        {cf.cte_type, cf.info_present, cf.cte_time});
      chk(8'(rx_hdr.ptype), 8'(cf.ptype));
      chk(8'(rx_info_bad), 8'h00);
    end
    repeat (1700) @(posedge mclk);
    #1;
  endtask
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) q.push_back(rx_data);
    if (rx_done === 1'b1) n_done++;
  end
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    $display("BAD %0t run hung", $time);
    close_out();
  end
  initial begin
    {ce, resetn, tx_start, rx_en, rx_phy_2m, rx_slot_2us} = 6'h20;
    {tx_cfg, ant_cfg, c} = '0;
    repeat (6) @(posedge mclk);
    #1 resetn = 1'b1;
    c.info_present = 1'b1;
    c.cte_time = 5'h15;
    tx_cfg = c;
    tx_start = 1'b1;
    @(posedge mclk);
    #1 tx_start = 1'b0;
    @(posedge mclk);
    #1 chk(8'(tx_busy), 8'h00);
    chk(8'(tx_en), 8'h00);
    for (int k = 0; k < 8; k++) begin
      c = 21'(rnd());
      c.ptype = 4'(k % 3);
      c.length = 8'(rnd() % 4 + 1);
      c.info_present = c.info_present || k < 2;
      c.cte_time = k < 2 ? (k ? 5'h14 : 5'h02) : 5'(rnd() % 19 + 2);
      c.cte_type = 2'(k % 3);
      if (!c.info_present) {c.cte_time, c.cte_type} = 7'h00;
      send(c, k != 5);
    end
    close_out();
  end
endmodule
`default_nettype wire
